// ==== logic/tls_top.sv ====
/*
  Torque limit selector: APB registers, request pins, limit choice and clamp.
  Assumes network option fields arrive on clk_sys_i; connector pins are async.
*/
`timescale 1ns/100ps
module tls_top #(
  parameter logic [tls_pkg::LIM_W-1:0] PAIR_MAX_PCT = tls_pkg::PCT_CEIL
) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire tls_pkg::tls_apb_req_s apb_req_i,
  output tls_pkg::tls_apb_rsp_s apb_rsp_o,
  input wire logic fwd_pin_i,
  input wire logic rev_pin_i,
  input wire tls_pkg::tls_net_opt_s net_opt_i,
  input wire logic signed [tls_pkg::TQ_W-1:0] torque_cmd_i,
  output logic signed [tls_pkg::TQ_W-1:0] torque_cmd_o,
  output logic [tls_pkg::LIM_W-1:0] fwd_limit_o,
  output logic [tls_pkg::LIM_W-1:0] rev_limit_o,
  output logic fwd_active_o,
  output logic rev_active_o
);
  import tls_pkg::*;

  // Pairing cap can never exceed the general ceiling
  localparam logic [LIM_W-1:0] CAP = (PAIR_MAX_PCT < PCT_CEIL) ? PAIR_MAX_PCT : PCT_CEIL;

  tls_state_s st_reg;
  tls_state_s st_next;
  logic [LIM_W-1:0] fwd_pick;
  logic [LIM_W-1:0] rev_pick;
  logic signed [TQ_W-1:0] pos_bound;
  logic signed [TQ_W-1:0] neg_bound;
  logic setup;
  logic mapped;
  logic wr_take;
  logic [DATA_W-1:0] rd_word;

  tls_dir_limit #(
    .REVERSE(1'b0)
  ) u_fwd (
    .sel_i(st_reg.sel),
    .mode_i(st_reg.mode),
    .ff_en_i(st_reg.ff_en),
    .lim1_i(st_reg.lim1),
    .lim2_i(st_reg.lim2),
    .req_i(st_reg.fwd_req),
    .net_value_i(net_opt_i.value1),
    .cap_i(CAP),
    .limit_o(fwd_pick)
  );

  tls_dir_limit #(
    .REVERSE(1'b1)
  ) u_rev (
    .sel_i(st_reg.sel),
    .mode_i(st_reg.mode),
    .ff_en_i(st_reg.ff_en),
    .lim1_i(st_reg.lim1),
    .lim2_i(st_reg.lim2),
    .req_i(st_reg.rev_req),
    .net_value_i(net_opt_i.value2),
    .cap_i(CAP),
    .limit_o(rev_pick)
  );

  always_comb begin
    st_next = st_reg;

    st_next.fwd_pin_s1 = fwd_pin_i;
    st_next.fwd_pin_s2 = st_reg.fwd_pin_s1;
    st_next.rev_pin_s1 = rev_pin_i;
    st_next.rev_pin_s2 = st_reg.rev_pin_s1;
    st_next.fwd_req = st_reg.fwd_pin_s2 | net_opt_i.fwd_flag;
    st_next.rev_req = st_reg.rev_pin_s2 | net_opt_i.rev_flag;

    st_next.fwd_lim = fwd_pick;
    st_next.rev_lim = rev_pick;

    // Clamp against the limits already registered, one cycle of latency
    pos_bound = signed'({{(TQ_W-LIM_W){1'b0}}, st_reg.fwd_lim});
    neg_bound = -signed'({{(TQ_W-LIM_W){1'b0}}, st_reg.rev_lim});
    if (torque_cmd_i > pos_bound) begin
      st_next.torque = pos_bound;
    end else if (torque_cmd_i < neg_bound) begin
      st_next.torque = neg_bound;
    end else begin
      st_next.torque = torque_cmd_i;
    end

    setup = apb_req_i.psel && !apb_req_i.penable;
    mapped = (apb_req_i.paddr == OFF_CTRL) || (apb_req_i.paddr == OFF_LIMIT1) ||
             (apb_req_i.paddr == OFF_LIMIT2) || (apb_req_i.paddr == OFF_CAP) ||
             (apb_req_i.paddr == OFF_STATUS);
    rd_word = '0;
    unique case (apb_req_i.paddr)
      OFF_CTRL: begin
        rd_word[CTRL_SEL_LSB +: 3] = st_reg.sel;
        rd_word[CTRL_MODE_LSB +: 2] = st_reg.mode;
        rd_word[CTRL_FF_BIT] = st_reg.ff_en;
      end
      OFF_LIMIT1: rd_word[LIM_W-1:0] = st_reg.lim1;
      OFF_LIMIT2: rd_word[LIM_W-1:0] = st_reg.lim2;
      OFF_CAP: rd_word[LIM_W-1:0] = CAP;
      OFF_STATUS: begin
        rd_word[LIM_W-1:0] = st_reg.fwd_lim;
        rd_word[STAT_REV_LSB +: LIM_W] = st_reg.rev_lim;
        rd_word[STAT_FREQ_BIT] = st_reg.fwd_req;
        rd_word[STAT_RREQ_BIT] = st_reg.rev_req;
      end
      default: rd_word = '0;
    endcase
    // Zero wait state: pready rises in the first access cycle
    st_next.rsp.pready = setup;
    st_next.rsp.pslverr = setup && !mapped;
    st_next.rsp.prdata = (setup && !apb_req_i.pwrite) ? rd_word : '0;

    wr_take = apb_req_i.psel && apb_req_i.penable && apb_req_i.pwrite &&
              st_reg.rsp.pready && !st_reg.rsp.pslverr;
    if (wr_take) begin
      unique case (apb_req_i.paddr)
        OFF_CTRL: begin
          st_next.sel = apb_req_i.pwdata[CTRL_SEL_LSB +: 3];
          // Unused mode code falls back to position control
          st_next.mode = (apb_req_i.pwdata[CTRL_MODE_LSB +: 2] == 2'h3) ? MODE_POS :
                         tls_mode_e'(apb_req_i.pwdata[CTRL_MODE_LSB +: 2]);
          st_next.ff_en = apb_req_i.pwdata[CTRL_FF_BIT];
        end
        OFF_LIMIT1: st_next.lim1 = tls_sat_pct(apb_req_i.pwdata, CAP);
        OFF_LIMIT2: st_next.lim2 = tls_sat_pct(apb_req_i.pwdata, CAP);
        default: st_next.sel = st_reg.sel;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st_reg <= '0;
      st_reg.sel <= SEL_RST;
      st_reg.mode <= MODE_RST;
      st_reg.lim1 <= CAP;
      st_reg.lim2 <= CAP;
      st_reg.fwd_lim <= CAP;
      st_reg.rev_lim <= CAP;
    end else begin
      st_reg <= st_next;
    end
  end

  assign apb_rsp_o = st_reg.rsp;
  assign torque_cmd_o = st_reg.torque;
  assign fwd_limit_o = st_reg.fwd_lim;
  assign rev_limit_o = st_reg.rev_lim;
  assign fwd_active_o = st_reg.fwd_req;
  assign rev_active_o = st_reg.rev_req;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  sequence s_fwd_pin_held;
    fwd_pin_i [*3];
  endsequence
  sequence s_rev_pin_held;
    rev_pin_i [*3];
  endsequence

  // Smaller of two percentages, shared by the minimum checks below
  function automatic logic [LIM_W-1:0] tls_min_pct(input logic [LIM_W-1:0] a,
                                                   input logic [LIM_W-1:0] b);
    return (a < b) ? a : b;
  endfunction : tls_min_pct

  a_limit_within_cap: assert property ((st_reg.lim1 <= CAP) && (st_reg.lim2 <= CAP))
    else $error("stored limit above pairing cap");
  a_reset_default: assert property ($past(srst_i) |-> (st_reg.lim1 == CAP))
    else $error("first limit not at cap after reset");
  a_both_first: assert property (
      (st_reg.sel == SEL_BOTH_FIRST) && !st_reg.ff_en
      |=> (fwd_limit_o == $past(st_reg.lim1)) && (rev_limit_o == $past(st_reg.lim1)))
    else $error("selection 1 limits wrong");
  a_split_forward: assert property (
      (st_reg.sel == SEL_SPLIT) && !st_reg.ff_en |=> fwd_limit_o == $past(st_reg.lim1))
    else $error("selection 2 forward limit wrong");
  a_split_reverse: assert property (
      (st_reg.sel == SEL_SPLIT) && !st_reg.ff_en |=> rev_limit_o == $past(st_reg.lim2))
    else $error("selection 2 reverse limit wrong");
  a_switch_forward: assert property (
      (st_reg.sel == SEL_REQ_SWITCH) && !st_reg.ff_en && st_reg.fwd_req
      |=> fwd_limit_o == $past(st_reg.lim2))
    else $error("selection 3 forward limit wrong");
  a_switch_reverse: assert property (
      (st_reg.sel == SEL_REQ_SWITCH) && !st_reg.ff_en
      |=> rev_limit_o == ($past(st_reg.rev_req) ? $past(st_reg.lim2) : $past(st_reg.lim1)))
    else $error("selection 3 reverse limit wrong");
  a_netmin_forward: assert property (
      (st_reg.sel == SEL_NET_MIN) && !st_reg.ff_en && (st_reg.mode == MODE_SPD)
      |=> fwd_limit_o == tls_min_pct($past(net_opt_i.value1), $past(st_reg.lim1)))
    else $error("selection 4 forward minimum wrong");
  a_netmin_reverse: assert property (
      (st_reg.sel == SEL_NET_MIN) && !st_reg.ff_en && (st_reg.mode == MODE_SPD)
      |=> rev_limit_o == tls_min_pct($past(net_opt_i.value2), $past(st_reg.lim2)))
    else $error("selection 4 reverse minimum wrong");
  a_netmin_stored: assert property (
      (st_reg.sel == SEL_NET_MIN) && !st_reg.ff_en && (st_reg.mode != MODE_SPD)
      |=> (fwd_limit_o == $past(st_reg.lim1)) && (rev_limit_o == $past(st_reg.lim2)))
    else $error("selection 4 outside speed control wrong");
  a_reqmin_active: assert property (
      (st_reg.sel == SEL_REQ_NET_MIN) && !st_reg.ff_en && (st_reg.mode == MODE_SPD)
      && st_reg.fwd_req
      |=> fwd_limit_o == tls_min_pct($past(net_opt_i.value1), $past(st_reg.lim1)))
    else $error("selection 5 forward minimum wrong");
  a_reqmin_idle: assert property (
      (st_reg.sel == SEL_REQ_NET_MIN) && !st_reg.ff_en && !st_reg.rev_req
      |=> rev_limit_o == $past(st_reg.lim2))
    else $error("selection 5 reverse limit wrong");
  a_ff_disables: assert property (
      st_reg.ff_en && (st_reg.sel == SEL_NET_MIN) |=> fwd_limit_o == CAP)
    else $error("selection 4 not disabled with feed-forward");
  a_ff_speed_only: assert property (
      st_reg.ff_en && (st_reg.mode != MODE_SPD) && (st_reg.sel == SEL_SPLIT)
      |=> (fwd_limit_o == CAP) && (rev_limit_o == CAP))
    else $error("selection 2 not disabled outside speed control");
  a_fwd_pin_req: assert property (s_fwd_pin_held |=> fwd_active_o)
    else $error("forward pin not seen as request");
  a_fwd_flag_req: assert property (net_opt_i.fwd_flag |=> fwd_active_o)
    else $error("forward network flag not seen as request");
  a_rev_pin_req: assert property (s_rev_pin_held |=> rev_active_o)
    else $error("reverse pin not seen as request");
  a_rev_flag_req: assert property (net_opt_i.rev_flag |=> rev_active_o)
    else $error("reverse network flag not seen as request");
  a_clamp_bounds: assert property (
      (torque_cmd_o <= signed'({3'h0, $past(fwd_limit_o)}))
      && (torque_cmd_o >= -signed'({3'h0, $past(rev_limit_o)})))
    else $error("torque command outside limits");
  a_clamp_pass: assert property (
      (torque_cmd_i <= signed'({3'h0, fwd_limit_o}))
      && (torque_cmd_i >= -signed'({3'h0, rev_limit_o}))
      |=> torque_cmd_o == $past(torque_cmd_i))
    else $error("torque command inside limits altered");
endmodule : tls_top

// ==== logic/tls_pkg.sv ====
/*
  Shared constants, carriers and helpers for the torque limit selector.
  Assumes one 10 MHz control clock and an APB master with 32-bit data.
*/
// What this block does
// - Each stored limit accepts 0 to 300 percent of rated torque and resets to the top of range.
// - A drive and motor pairing may cap the highest allowed limit below 300 percent.
// - Selection 1 puts the first limit on both directions, selection 2 splits first and second.
// - Selection 3 swaps a direction to the second limit while that direction's request is active.
// - Selection 4 uses first and second limits, in speed control taking the smaller network value.
// - Selection 5 does the same as 4 only while the direction's request is active.
// - With feed-forward, selections 1 to 3 act only in speed control and 4 and 5 never act.
// - The forward request is the OR of the connector pin and the network flag.
package tls_pkg;
  localparam int LIM_W = 9;
  localparam int TQ_W = 12;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [LIM_W-1:0] PCT_CEIL = 9'h12C;

  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_LIMIT1 = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_LIMIT2 = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_CAP = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h10;

  localparam int CTRL_SEL_LSB = 0;
  localparam int CTRL_MODE_LSB = 4;
  localparam int CTRL_FF_BIT = 8;
  localparam int STAT_REV_LSB = 16;
  localparam int STAT_FREQ_BIT = 28;
  localparam int STAT_RREQ_BIT = 29;

  localparam logic [2:0] SEL_BOTH_FIRST = 3'h1;
  localparam logic [2:0] SEL_SPLIT = 3'h2;
  localparam logic [2:0] SEL_REQ_SWITCH = 3'h3;
  localparam logic [2:0] SEL_NET_MIN = 3'h4;
  localparam logic [2:0] SEL_REQ_NET_MIN = 3'h5;
  localparam logic [2:0] SEL_RST = SEL_BOTH_FIRST;

  typedef enum logic [1:0] {
    MODE_POS = 2'h0,
    MODE_SPD = 2'h1,
    MODE_TRQ = 2'h2
  } tls_mode_e;
  localparam tls_mode_e MODE_RST = MODE_POS;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } tls_apb_req_s;

  typedef struct packed {
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
  } tls_apb_rsp_s;

  typedef struct packed {
    logic fwd_flag;
    logic rev_flag;
    logic [LIM_W-1:0] value1;
    logic [LIM_W-1:0] value2;
  } tls_net_opt_s;

  typedef struct packed {
    logic [2:0] sel;
    tls_mode_e mode;
    logic ff_en;
    logic [LIM_W-1:0] lim1;
    logic [LIM_W-1:0] lim2;
    logic fwd_pin_s1;
    logic fwd_pin_s2;
    logic rev_pin_s1;
    logic rev_pin_s2;
    logic fwd_req;
    logic rev_req;
    logic [LIM_W-1:0] fwd_lim;
    logic [LIM_W-1:0] rev_lim;
    logic signed [TQ_W-1:0] torque;
    tls_apb_rsp_s rsp;
  } tls_state_s;

  // Out of range writes saturate instead of wrapping
  function automatic logic [LIM_W-1:0] tls_sat_pct(input logic [DATA_W-1:0] val,
                                                   input logic [LIM_W-1:0] cap);
    if (val > {{(DATA_W-LIM_W){1'b0}}, cap}) begin
      return cap;
    end
    return val[LIM_W-1:0];
  endfunction : tls_sat_pct
endpackage : tls_pkg

// ==== logic/tls_dir_limit.sv ====
/*
  Limit choice for one torque direction from the selection and its sources.
  Assumes stored limits are already within the pairing cap.
*/
`timescale 1ns/100ps
module tls_dir_limit #(
  parameter bit REVERSE = 1'b0
) (
  input wire logic [2:0] sel_i,
  input wire tls_pkg::tls_mode_e mode_i,
  input wire logic ff_en_i,
  input wire logic [tls_pkg::LIM_W-1:0] lim1_i,
  input wire logic [tls_pkg::LIM_W-1:0] lim2_i,
  input wire logic req_i,
  input wire logic [tls_pkg::LIM_W-1:0] net_value_i,
  input wire logic [tls_pkg::LIM_W-1:0] cap_i,
  output logic [tls_pkg::LIM_W-1:0] limit_o
);
  import tls_pkg::*;

  logic [LIM_W-1:0] stored;
  logic [LIM_W-1:0] net_min;
  logic speed;
  logic honoured;

  always_comb begin
    stored = REVERSE ? lim2_i : lim1_i;
    net_min = (net_value_i < stored) ? net_value_i : stored;
    speed = (mode_i == MODE_SPD);
    honoured = !ff_en_i || (speed && (sel_i >= SEL_BOTH_FIRST) && (sel_i <= SEL_REQ_SWITCH));
    case (sel_i)
      SEL_BOTH_FIRST: limit_o = lim1_i;
      SEL_SPLIT: limit_o = stored;
      SEL_REQ_SWITCH: limit_o = req_i ? lim2_i : lim1_i;
      SEL_NET_MIN: limit_o = speed ? net_min : stored;
      SEL_REQ_NET_MIN: limit_o = (speed && req_i) ? net_min : stored;
      default: limit_o = cap_i;
    endcase
    // A disabled selection leaves only the pairing ceiling in force
    if (!honoured) begin
      limit_o = cap_i;
    end
  end
endmodule : tls_dir_limit

// ==== verif/tls_host_model.sv ====
/*
  Host side model: APB master and the network option fields.
  Assumes the selector answers APB with a registered pready.
*/
`timescale 1ns/100ps
module tls_host_model (
  input wire logic clk_sys_i,
  output tls_pkg::tls_apb_req_s apb_req_o,
  input wire tls_pkg::tls_apb_rsp_s apb_rsp_i,
  output tls_pkg::tls_net_opt_s net_opt_o
);
  import tls_pkg::*;
  initial begin
    apb_req_o = '0;
    net_opt_o = '0;
  end
  task automatic apb_xfer(input logic wr, input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] rdat,
                          output logic err, output bit hung);
    @(posedge clk_sys_i);
    apb_req_o <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk_sys_i);
    apb_req_o.penable <= 1'b1;
    hung = 1'b1;
    for (int i = 0; i < 16 && hung; i++) begin
      @(posedge clk_sys_i);
      hung = (apb_rsp_i.pready !== 1'b1);
    end
    rdat = apb_rsp_i.prdata;
    err = apb_rsp_i.pslverr;
    // Stale address and data inverted so nothing looks valid when idle
    apb_req_o <= '{psel: 1'b0, penable: 1'b0, pwrite: ~wr, paddr: ~a, pwdata: ~d};
  endtask : apb_xfer
  task automatic set_net(input tls_net_opt_s val);
    @(posedge clk_sys_i);
    net_opt_o <= val;
  endtask : set_net
endmodule : tls_host_model

// ==== verif/test_tls_top.sv ====
/*
  Self-checking bench for the torque limit selector against an integer model.
  Assumes the host model above and a pairing cap of 250 percent.
*/
`timescale 1ns/100ps
module test_tls_top;
  import tls_pkg::*;
  localparam int CAP = 250;
  logic clk_sys_i = 1'b0;
  logic srst_i = 1'b1;
  logic fwd_pin_i = 1'b0;
  logic rev_pin_i = 1'b0;
  logic signed [TQ_W-1:0] torque_cmd_i = '0;
  logic signed [TQ_W-1:0] torque_cmd_o;
  tls_apb_req_s apb_req;
  tls_apb_rsp_s apb_rsp;
  tls_net_opt_s net_opt;
  logic [LIM_W-1:0] fwd_limit_o;
  logic [LIM_W-1:0] rev_limit_o;
  logic fwd_active_o;
  logic rev_active_o;
  logic [DATA_W-1:0] rdat;
  logic err;
  bit hung;
  int fails = 0;
  int total_checks = 0;
  int exp_q[$];

  always #50 clk_sys_i = ~clk_sys_i;

  tls_top #(.PAIR_MAX_PCT(9'h0FA)) DUT (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
    .apb_req_i(apb_req), .apb_rsp_o(apb_rsp), .fwd_pin_i(fwd_pin_i), .rev_pin_i(rev_pin_i),
    .net_opt_i(net_opt), .torque_cmd_i(torque_cmd_i), .torque_cmd_o(torque_cmd_o),
    .fwd_limit_o(fwd_limit_o), .rev_limit_o(rev_limit_o), .fwd_active_o(fwd_active_o),
    .rev_active_o(rev_active_o));
  tls_host_model host (.clk_sys_i(clk_sys_i), .apb_req_o(apb_req), .apb_rsp_i(apb_rsp),
    .net_opt_o(net_opt));

  task automatic complete_run;
    $display("checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  task automatic check(input string what, input logic [DATA_W-1:0] exp,
                       input logic [DATA_W-1:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input int d);
    host.apb_xfer(wr, a, DATA_W'(d), rdat, err, hung);
    if (hung) begin
      fails++;
      complete_run();
    end
  endtask : apb

  // Limit for one direction; own is that direction's stored limit
  function automatic int exp_lim(int sel, int mode, int ff, int l1, int own, int l2,
                                 int req, int v);
    int spd = (mode == 1);
    if (ff != 0 && (sel > 3 || spd == 0)) return CAP;
    case (sel)
      1: return l1;
      2: return own;
      3: return (req != 0) ? l2 : l1;
      4: return (spd != 0 && v < own) ? v : own;
      5: return (spd != 0 && req != 0 && v < own) ? v : own;
      default: return CAP;
    endcase
  endfunction : exp_lim

  initial begin
    int sel, mode, ff, l1, l2, fr, rr, tq, ef, er, et;
    tls_net_opt_s n;
    void'($urandom(33));
    repeat (8) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    apb(0, OFF_CTRL, 0);
    check("ctrl reset", 1, rdat);
    apb(0, OFF_LIMIT1, 0);
    check("limit1 reset", CAP, rdat);
    apb(0, OFF_LIMIT2, 0);
    check("limit2 reset", CAP, rdat);
    apb(1, OFF_LIMIT1, 300);
    apb(0, OFF_LIMIT1, 0);
    check("limit1 above cap", CAP, rdat);
    apb(1, OFF_CAP, 100);
    apb(0, OFF_CAP, 0);
    check("cap read only", CAP, rdat);
    apb(0, 8'h20, 0);
    check("unmapped error", 1, err);
    $display("test registers done");
    for (int i = 0; i < 240; i++) begin
      sel = i % 8;
      mode = (i / 8) % 4;
      ff = (i / 32) % 2;
      if (mode == 2) sel = 1;
      l1 = $urandom_range(300);
      l2 = $urandom_range(300);
      n.fwd_flag = 1'($urandom_range(1));
      n.rev_flag = 1'($urandom_range(1));
      n.value1 = LIM_W'($urandom_range(300));
      n.value2 = LIM_W'($urandom_range(300));
      tq = int'($urandom_range(4095)) - 2048;
      apb(1, OFF_CTRL, sel + mode * 16 + ff * 256);
      apb(1, OFF_LIMIT1, l1);
      apb(1, OFF_LIMIT2, l2);
      host.set_net(n);
      fwd_pin_i <= 1'($urandom_range(1));
      rev_pin_i <= 1'($urandom_range(1));
      torque_cmd_i <= TQ_W'(tq);
      // Pin path to the clamp takes five edges
      repeat (6) @(posedge clk_sys_i);
      // Look at outputs away from the launching edge
      @(negedge clk_sys_i);
      if (mode == 3) mode = 0;
      l1 = (l1 > CAP) ? CAP : l1;
      l2 = (l2 > CAP) ? CAP : l2;
      fr = n.fwd_flag | fwd_pin_i;
      rr = n.rev_flag | rev_pin_i;
      exp_q.push_back(exp_lim(sel, mode, ff, l1, l1, l2, fr, n.value1));
      exp_q.push_back(exp_lim(sel, mode, ff, l1, l2, l2, rr, n.value2));
      ef = exp_q.pop_front();
      er = exp_q.pop_front();
      et = (tq > ef) ? ef : ((tq < -er) ? -er : tq);
      check("fwd active", fr, fwd_active_o);
      check("rev active", rr, rev_active_o);
      check("fwd limit", ef, fwd_limit_o);
      check("rev limit", er, rev_limit_o);
      check("torque out", DATA_W'(et), DATA_W'(int'(torque_cmd_o)));
      apb(0, OFF_CTRL, 0);
      check("ctrl readback", sel + mode * 16 + ff * 256, rdat);
      apb(0, OFF_STATUS, 0);
      check("status", ef + er * 65536 + fr * (1 << 28) + rr * (1 << 29), rdat);
    end
    $display("test selection table done");
    // Reset in mid-run must bring every limit back to the cap
    srst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    apb(0, OFF_LIMIT2, 0);
    check("limit2 after reset", CAP, rdat);
    apb(0, OFF_CTRL, 0);
    check("ctrl after reset", 1, rdat);
    check("fwd limit after reset", CAP, fwd_limit_o);
    check("rev limit after reset", CAP, rev_limit_o);
    $display("test mid-run reset done");
    complete_run();
  end

  initial begin
    #(100 * 90000);
    fails++;
    complete_run();
  end
endmodule : test_tls_top
